/* File: rtl/serirq_consts.svh */
// register offsets, field positions, reset values and frame timing of the serial irq block
// assumes a 32-bit word bus with each register on one aligned word
`ifndef SERIRQ_CONSTS_SVH
`define SERIRQ_CONSTS_SVH

// printed offsets are not all multiples of four: they are indices, byte address = 4 * index
`define IDX_MODE            8'h48
`define IDX_TRIG            8'h4A
`define IDX_FLAG            8'h4C
`define ADDR_MODE           10'h120
`define ADDR_TRIG           10'h128
`define ADDR_FLAG           10'h130

`define MODE_RESET          8'h00
`define TRIG_RESET          16'h0000
`define FLAG_RESET          16'h0000
`define MODE_WMASK          8'h0F
`define F_DRIVE             0
`define F_POLL              1
`define F_WIDTH_LO          2

`define START_W0            4'h4
`define START_W1            4'h6
`define START_W2            4'h8
`define SLOT_CLKS           2'h3
`define STOP_CLKS           2'h2
`define IDLE_GAP            8'h10

`endif

/* File: rtl/serirq_ctrl.sv */
// serial irq controller: mode, trigger type and level latch registers plus frame engine
// assumes an ahb-lite master on CLK and one shared open-drain serial irq line clocked by CLK
`timescale 1ns/100ps
`include "serirq_consts.svh"

module serirq_ctrl #(
    parameter int SLOTS = 16
) (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        LINK_RESETN,
    input  wire logic        POR_RESETN,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        SERIRQ_I,
    output logic             SERIRQ_O,
    output logic             SERIRQ_OEN,
    output logic [SLOTS-1:0] SLOT_ACTIVE
);

    if (SLOTS != 16) begin : slots_check
        $error("serirq_ctrl serves exactly 16 slots");
    end

    // ==========================================================
    // state
    typedef struct packed {
        serirq_pkg::bus_req_t  req;
        logic [7:0]            mode;
        logic [15:0]           trig;
        logic [15:0]           flag;
        logic [31:0]           rdata;
        serirq_pkg::frame_st_t st;
        logic [3:0]            cnt;
        logic [3:0]            slot;
        logic [1:0]            phase;
        logic [7:0]            gap;
        logic                  drv_low;
        logic                  drv_high;
        logic [15:0]           active;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic   rst_n;

    assign rst_n = RESETN & LINK_RESETN & POR_RESETN;

    // ==========================================================
    // helpers
    function automatic logic [3:0] start_len(input logic [1:0] w);
        unique case (w)
            2'b00:   start_len = `START_W0;
            2'b01:   start_len = `START_W1;
            2'b10:   start_len = `START_W2;
            default: start_len = `START_W0;
        endcase
    endfunction

    function automatic logic [31:0] read_word(input logic [9:0] a, input state_t s);
        unique case (a)
            `ADDR_MODE: read_word = {24'h000000, s.mode};
            `ADDR_TRIG: read_word = {16'h0000, s.trig};
            `ADDR_FLAG: read_word = {16'h0000, s.flag};
            default:    read_word = 32'h00000000;
        endcase
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        serirq_pkg::mode_t md;
        logic [15:0]       clr;
        logic [15:0]       setf;
        logic              wr;
        s_nxt = s_r;
        md    = s_r.mode[3:0];
        clr   = 16'h0000;
        setf  = 16'h0000;
        wr    = s_r.req.sel & s_r.req.hwrite;

        // bus: address phase captured, data phase applied
        s_nxt.req.sel    = HSEL & HREADY & HTRANS[1];
        s_nxt.req.haddr  = HADDR;
        s_nxt.req.hwrite = HWRITE;
        if (HSEL & HREADY & HTRANS[1] & ~HWRITE) begin
            s_nxt.rdata = read_word(HADDR[9:0], s_r);
        end
        if (wr && s_r.req.haddr[9:0] == `ADDR_MODE) begin
            s_nxt.mode = HWDATA[7:0] & `MODE_WMASK;
        end
        if (wr && s_r.req.haddr[9:0] == `ADDR_TRIG) begin
            s_nxt.trig = HWDATA[15:0];
        end
        if (wr && s_r.req.haddr[9:0] == `ADDR_FLAG) begin
            clr = HWDATA[15:0];
        end

        // the line shares CLK with every peripheral: sampled directly, a one-clock request counts

        s_nxt.drv_low  = 1'b0;
        s_nxt.drv_high = 1'b0;
        unique case (s_r.st)
            serirq_pkg::ST_IDLE: begin
                // continuous starts the next frame as soon as the idle gap ends; quiet waits for a peripheral
                if (!md.quiet || !SERIRQ_I) begin
                    s_nxt.st      = serirq_pkg::ST_START;
                    s_nxt.cnt     = start_len(md.start_width) - 4'h1;
                    s_nxt.drv_low = 1'b1;
                end
            end
            serirq_pkg::ST_START: begin
                s_nxt.drv_low = s_r.cnt != 4'h0;
                s_nxt.cnt     = s_r.cnt - 4'h1;
                if (s_r.cnt == 4'h0) begin
                    s_nxt.st       = serirq_pkg::ST_RECOV_START;
                    s_nxt.drv_high = ~md.float_recov;
                end
            end
            serirq_pkg::ST_RECOV_START: begin
                s_nxt.st    = serirq_pkg::ST_SLOT;
                s_nxt.slot  = 4'h0;
                s_nxt.phase = 2'h0;
            end
            serirq_pkg::ST_SLOT: begin
                // slot: sample, recovery, turnaround; sample taken in phase 1
                if (s_r.phase == 2'h1) begin
                    for (int i = 0; i < 16; i++) begin
                        if (s_r.slot == 4'(i)) begin
                            s_nxt.active[i] = ~SERIRQ_I;
                            setf[i] = ~SERIRQ_I & s_r.trig[i];
                        end
                    end
                end
                s_nxt.phase = s_r.phase + 2'h1;
                if (s_r.phase == `SLOT_CLKS - 2'h1) begin
                    s_nxt.phase = 2'h0;
                    s_nxt.slot  = s_r.slot + 4'h1;
                    if (s_r.slot == 4'hF) begin
                        s_nxt.st      = serirq_pkg::ST_STOP;
                        s_nxt.cnt     = {2'b00, `STOP_CLKS} - 4'h1;
                        s_nxt.drv_low = 1'b1;
                    end
                end
            end
            serirq_pkg::ST_STOP: begin
                s_nxt.drv_low = s_r.cnt != 4'h0;
                s_nxt.cnt     = s_r.cnt - 4'h1;
                if (s_r.cnt == 4'h0) begin
                    s_nxt.st       = serirq_pkg::ST_GAP;
                    s_nxt.gap      = `IDLE_GAP;
                    s_nxt.drv_high = ~md.float_recov;
                end
            end
            serirq_pkg::ST_GAP: begin
                s_nxt.gap = s_r.gap - 8'h01;
                if (s_r.gap == 8'h00) begin
                    s_nxt.st = serirq_pkg::ST_IDLE;
                end
            end
        endcase

        // set beats clear in the same cycle
        s_nxt.flag = (s_r.flag & ~clr) | setf;
    end

    // ==========================================================
    // registers
    always_ff @(posedge CLK) begin
        if (!rst_n) begin
            s_r      <= '0;
            s_r.st   <= serirq_pkg::ST_IDLE;
            s_r.mode <= `MODE_RESET;
            s_r.trig <= `TRIG_RESET;
            s_r.flag <= `FLAG_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign HRDATA      = s_r.rdata;
    assign HREADYOUT   = 1'b1;
    assign HRESP       = 1'b0;
    assign SERIRQ_O    = ~s_r.drv_low;
    assign SERIRQ_OEN  = ~(s_r.drv_low | s_r.drv_high);
    assign SLOT_ACTIVE = s_r.active;

    // ==========================================================
    // assertions
    start_width_a: assert property (@(posedge CLK) disable iff (!rst_n)
        $rose(s_r.st == serirq_pkg::ST_START) && $past(s_r.mode[3:2]) == 2'b01
        |-> (s_r.st == serirq_pkg::ST_START)[*6] ##1 s_r.st != serirq_pkg::ST_START)
        else $error("start frame width wrong");
    quiet_hold_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.st == serirq_pkg::ST_IDLE && s_r.mode[1] && SERIRQ_I
        |=> s_r.st == serirq_pkg::ST_IDLE)
        else $error("quiet mode started without request");
    recov_drive_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.drv_high |-> !$past(s_r.mode[0]) && !SERIRQ_OEN && SERIRQ_O)
        else $error("recovery drive wrong");
    reserved_field_zero_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.mode[7:4] == 4'h0)
        else $error("reserved mode bits set");
    trig_write_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.req.sel && s_r.req.hwrite && s_r.req.haddr[9:0] == `ADDR_TRIG
        |=> s_r.trig == $past(HWDATA[15:0]))
        else $error("trigger write lost");
    level_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.st == serirq_pkg::ST_SLOT && s_r.phase == 2'h1 && !SERIRQ_I
        && s_r.trig[s_r.slot] |=> s_r.flag[$past(s_r.slot)])
        else $error("level flag not set");
    clear_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.req.sel && s_r.req.hwrite && s_r.req.haddr[9:0] == `ADDR_FLAG
        && s_r.st != serirq_pkg::ST_SLOT |=> (s_r.flag & $past(HWDATA[15:0])) == 16'h0000)
        else $error("flag clear failed");
    edge_none_a: assert property (@(posedge CLK) disable iff (!rst_n)
        ((s_r.flag & ~$past(s_r.flag)) & ~$past(s_r.trig)) == 16'h0000)
        else $error("edge slot set a flag");
    stop_after_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.st == serirq_pkg::ST_SLOT && s_r.slot == 4'hF && s_r.phase == 2'h2
        |=> s_r.st == serirq_pkg::ST_STOP)
        else $error("stop frame missing");
    flag_read_a: assert property (@(posedge CLK) disable iff (!rst_n)
        HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[9:0] == `ADDR_FLAG
        |=> HRDATA[15:0] == $past(s_r.flag))
        else $error("flag readback wrong");
    reset_clear_a: assert property (@(posedge CLK)
        !rst_n |=> s_r.mode == 8'h00 && s_r.trig == 16'h0000 && s_r.flag == 16'h0000)
        else $error("reset did not clear");
    start_drive_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.st == serirq_pkg::ST_START |-> !SERIRQ_OEN && !SERIRQ_O)
        else $error("start frame not driven low");
    idle_leave_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.st == serirq_pkg::ST_IDLE && (!s_r.mode[1] || !SERIRQ_I)
        |=> s_r.st == serirq_pkg::ST_START)
        else $error("frame did not start");
    float_recov_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.st == serirq_pkg::ST_RECOV_START && $past(s_r.mode[0]) |-> SERIRQ_OEN)
        else $error("recovery not floated");
    mode_read_a: assert property (@(posedge CLK) disable iff (!rst_n)
        HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[9:0] == `ADDR_MODE
        |=> HRDATA[31:4] == 28'h0000000)
        else $error("reserved mode bits read back");
    level_hold_a: assert property (@(posedge CLK) disable iff (!rst_n)
        !(s_r.req.sel && s_r.req.hwrite && s_r.req.haddr[9:0] == `ADDR_FLAG)
        |=> (s_r.flag & $past(s_r.flag)) == $past(s_r.flag))
        else $error("flag dropped without clear");
    recov_one_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.st == serirq_pkg::ST_RECOV_START
        |=> s_r.st == serirq_pkg::ST_SLOT && s_r.slot == 4'h0 && s_r.phase == 2'h0)
        else $error("slots did not follow start");
    slot_idle_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.st == serirq_pkg::ST_SLOT |-> SERIRQ_OEN)
        else $error("device drove a slot");
    active_track_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.st == serirq_pkg::ST_SLOT && s_r.phase == 2'h1
        |=> SLOT_ACTIVE[$past(s_r.slot)] == $past(!SERIRQ_I))
        else $error("slot activity lost");
    stop_drive_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.st == serirq_pkg::ST_STOP |-> !SERIRQ_OEN && !SERIRQ_O)
        else $error("stop frame not driven low");
    gap_len_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_r.st == serirq_pkg::ST_STOP && s_r.cnt == 4'h0
        |=> s_r.st == serirq_pkg::ST_GAP ##17 s_r.st == serirq_pkg::ST_IDLE)
        else $error("idle gap length wrong");

    // ==========================================================
    // main scenarios

    frame_done_c: cover property (@(posedge CLK) disable iff (!rst_n)
        s_r.st == serirq_pkg::ST_STOP);
    level_hit_c: cover property (@(posedge CLK) disable iff (!rst_n) |s_r.flag);
    quiet_start_c: cover property (@(posedge CLK) disable iff (!rst_n)
        s_r.mode[1] && $rose(s_r.st == serirq_pkg::ST_START));
    width8_c: cover property (@(posedge CLK) disable iff (!rst_n)
        $rose(s_r.st == serirq_pkg::ST_START) && $past(s_r.mode[3:2]) == 2'b10);
    rearm_c: cover property (@(posedge CLK) disable iff (!rst_n)
        s_r.req.sel && s_r.req.hwrite && s_r.req.haddr[9:0] == `ADDR_FLAG
        && |(s_r.flag & HWDATA[15:0]));

endmodule

/* File: rtl/serirq_pkg.sv */
// types shared by the serial irq block
// constants live in serirq_consts.svh
package serirq_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_RECOV_START,
        ST_SLOT,
        ST_STOP,
        ST_GAP
    } frame_st_t;

    typedef struct packed {
        logic [31:0] haddr;
        logic        hwrite;
        logic        sel;
    } bus_req_t;

    typedef struct packed {
        logic [1:0] start_width;
        logic       quiet;
        logic       float_recov;
    } mode_t;

endpackage

/* File: tb/serial_irq_mode_edge_status_test.sv */
// testbench for the serial irq controller over ahb-lite
// assumes the peripheral model on the line and the design constants header
`timescale 1ns/100ps
`include "serirq_consts.svh"
module serial_irq_mode_edge_status_test;
    // ==========================================
    // signals
    logic        CLK = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, kick = 1'b0;
    logic [2:0]  rst_n = 3'h0;
    logic [1:0]  HTRANS = 2'h0, rec = 2'h0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, tmp;
    logic        HREADYOUT, SERIRQ_O, SERIRQ_OEN, line, pull_low;
    logic [15:0] SLOT_ACTIVE, req = 16'h0;
    int          n_errors = 0, n_compared = 0, n_starts = 0, run = 0, start_len = 0;
    localparam logic [31:0] a_mode = {22'h0, `ADDR_MODE};
    localparam logic [31:0] a_trig = {22'h0, `ADDR_TRIG};
    localparam logic [31:0] a_flag = {22'h0, `ADDR_FLAG};

    always #20 CLK = ~CLK;
    assign line = !((!SERIRQ_OEN && !SERIRQ_O) || pull_low);

    serirq_ctrl dut (.CLK(CLK), .RESETN(rst_n[0]), .LINK_RESETN(rst_n[1]),
        .POR_RESETN(rst_n[2]), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(), .SERIRQ_I(line),
        .SERIRQ_O(SERIRQ_O), .SERIRQ_OEN(SERIRQ_OEN), .SLOT_ACTIVE(SLOT_ACTIVE));
    serirq_peripheral peer (.CLK(CLK), .RESETN(&rst_n), .LINE(line), .REQ(req),
        .KICK(kick), .PULL_LOW(pull_low));

    // ==========================================
    // start frame monitor
    always @(posedge CLK) begin
        if (!SERIRQ_OEN && !SERIRQ_O) begin
            run <= run + 1;
        end else begin
            if (run >= 4) begin
                start_len <= run;
                rec <= {SERIRQ_OEN, SERIRQ_O};
                n_starts <= n_starts + 1;
            end
            run <= 0;
        end
    end

    // ==========================================
    // tasks
    task results;
        if (n_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task timeout;
        n_errors++;
        $display("mismatch at %0t: wait timed out", $time);
        results;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wait_ready;
        int i;
        i = 0;
        do begin
            @(posedge CLK);
            i++;
        end while (HREADYOUT !== 1'b1 && i < 50);
        if (HREADYOUT !== 1'b1) timeout;
    endtask
    task xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= wr;
        wait_ready;
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        wait_ready;
        tmp = HRDATA;
    endtask
    task rchk(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(tmp, exp);
    endtask
    task wait_frames(input int n);
        int i, s;
        s = n_starts;
        for (i = 0; i < 200 * n && n_starts < s + n; i++) @(posedge CLK);
        if (n_starts < s + n) timeout;
    endtask

    // ==========================================
    // sequence
    initial begin
        int s;
        repeat (5) @(posedge CLK);
        rst_n <= 3'h7;
        rchk(a_mode, 32'h0);
        rchk(a_trig, 32'h0);
        rchk(a_flag, 32'h0);
        rchk(32'h134, 32'h0);
        xfer(1'b1, a_mode, 32'hFF);
        rchk(a_mode, 32'h0F);
        for (int w = 0; w < 3; w++) begin
            xfer(1'b1, a_mode, 32'(w << 2));
            wait_frames(2);
            chk(start_len, 32'(4 + 2 * w));
            chk({30'h0, rec}, 32'h1);
        end
        xfer(1'b1, a_mode, 32'h1);
        wait_frames(2);
        chk({31'h0, rec[1]}, 32'h1);
        xfer(1'b1, a_trig, 32'hA5C3);
        rchk(a_trig, 32'hA5C3);
        req <= 16'hFFFF;
        wait_frames(3);
        rchk(a_flag, 32'hA5C3);
        chk({16'h0, SLOT_ACTIVE}, 32'hFFFF);
        req <= 16'h0;
        wait_frames(2);
        rchk(a_flag, 32'hA5C3);
        chk({16'h0, SLOT_ACTIVE}, 32'h0);
        xfer(1'b1, a_flag, 32'h00C3);
        rchk(a_flag, 32'hA500);
        req <= 16'hFFFF;
        wait_frames(2);
        rchk(a_flag, 32'hA5C3);
        xfer(1'b1, a_mode, 32'h2);
        repeat (100) @(posedge CLK);
        s = n_starts;
        repeat (200) @(posedge CLK);
        chk(n_starts, s);
        kick <= 1'b1;
        @(posedge CLK);
        kick <= 1'b0;
        wait_frames(1);
        chk(start_len, 32'h4);
        for (int k = 0; k < 3; k++) begin
            xfer(1'b1, a_mode, 32'h5);
            xfer(1'b1, a_trig, 32'hFFFF);
            wait_frames(2);
            rst_n[k] <= 1'b0;
            repeat (2) @(posedge CLK);
            rst_n <= 3'h7;
            rchk(a_mode, 32'h0);
            rchk(a_trig, 32'h0);
            rchk(a_flag, 32'h0);
        end
        results;
    end
endmodule

/* File: tb/serirq_peripheral.sv */
// peripheral model on the serial irq line: pulls low in requested slots
// assumes the bench resolves the open-drain line with a pull-up
`timescale 1ns/100ps
module serirq_peripheral (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        LINE,
    input  wire logic [15:0] REQ,
    input  wire logic        KICK,
    output logic             PULL_LOW
);
    // ==========================================
    // frame tracking
    logic [3:0] run_r;
    logic [6:0] pos_r;
    logic       act_r;
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            run_r <= 4'h0;
            pos_r <= 7'h00;
            act_r <= 1'b0;
            PULL_LOW <= 1'b0;
        end else begin
            run_r <= (LINE || act_r) ? 4'h0 : run_r + {3'h0, run_r != 4'hF};
            if (LINE && !act_r && run_r >= 4'h4) begin
                act_r <= 1'b1;
                pos_r <= 7'h00;
                PULL_LOW <= REQ[0];
            end else if (act_r && pos_r < 7'h2F) begin
                pos_r <= pos_r + 7'h01;
                PULL_LOW <= REQ[(pos_r + 7'h01) / 7'h03];
            end else begin
                act_r <= 1'b0;
                PULL_LOW <= KICK && LINE && !PULL_LOW;
            end
        end
    end
endmodule
